// ===== verilog/out_sync_pkg.sv
// Constants and types for the output frequency and sync enable registers
package out_sync_pkg;

  localparam logic [7:0] ADDR_FIRST_OUT = 8'h62;
  localparam logic [7:0] ADDR_SYNC_EN = 8'h63;
  localparam logic [7:0] SYNC_EN_RESET = 8'hC0;
  localparam int MF_EN_BIT = 7;
  localparam int FR_EN_BIT = 6;
  localparam int FIELD_LSB = 4;

  localparam int CLK_MHZ = 100;
  localparam int INIT_MS = 251;
  // One product with no intermediate blow-up, so the 32-bit constant cannot overflow
  localparam int INIT_CYCLES = INIT_MS * CLK_MHZ * 1000;

  // Source of the selected first-output clock
  typedef enum logic [2:0] {
    SRC_OFF = 3'h0,
    SRC_2K = 3'h1,
    SRC_8K = 3'h2,
    SRC_FIRST_ANALOG_PLL = 3'h3,
    SRC_SECOND_ANALOG_PLL = 3'h4,
    SRC_DIGITAL = 3'h5
  } out_src_t;

  typedef struct packed {
    out_src_t src;
    logic [5:0] divide;
  } out_sel_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// ===== verilog/output_freq_sync_enable_regs.sv
// Output frequency select and sync enable register bank
`timescale 1ns/1ps
module output_freq_sync_enable_regs
  import out_sync_pkg::*;
#(
  parameter int INIT_COUNT = INIT_CYCLES
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Board strap pins
  input wire logic [2:0] i_first_output_strap_pins,
  input wire logic i_sonet_sdh_select_pin,
  // Register access from the serial port
  input wire reg_req_t i_req,
  output logic [7:0] o_rdata,
  output logic o_init_done,
  // Decoded output selection and sync enables
  output out_sel_t o_first_out_sel,
  output logic o_multiframe_sync_enable,
  output logic o_frame_sync_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // Request decode, shared by every register that takes host writes
  function automatic logic wr_hit(input reg_req_t r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchronisers: a change counts once stages two and three agree
  logic [3:0] strap_s1_q, strap_s2_q, strap_s3_q, strap_q;
  always_ff @(posedge i_ref_clk) begin
    strap_s1_q <= {i_sonet_sdh_select_pin, i_first_output_strap_pins};
    strap_s2_q <= strap_s1_q;
    strap_s3_q <= strap_s2_q;
    if (strap_s2_q == strap_s3_q) begin
      strap_q <= strap_s3_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Initialization timer after reset release
  // Host writes to the output field stay closed until the count runs out
  typedef enum logic [1:0] {
    INIT_WAIT = 2'b01,
    INIT_OPEN = 2'b10
  } init_state_t;
  init_state_t init_state_q;
  logic [31:0] init_cnt_q;
  logic init_done;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      init_state_q <= INIT_WAIT;
    end else begin
      unique case (init_state_q)
        INIT_WAIT: begin
          if (init_cnt_q >= 32'(INIT_COUNT - 1)) begin
            init_state_q <= INIT_OPEN;
          end
        end
        INIT_OPEN: begin
          init_state_q <= INIT_OPEN;
        end
        default: begin
          init_state_q <= INIT_WAIT;
        end
      endcase
    end
  end

  // Counter stops once the window opens, so it never wraps in a long run
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      init_cnt_q <= '0;
    end else if (init_state_q == INIT_WAIT) begin
      init_cnt_q <= init_cnt_q + 32'h1;
    end
  end

  assign init_done = (init_state_q == INIT_OPEN);
  assign o_init_done = init_done;

  ////////////////////////////////////////////////////////////////////////////
  // First output field: strap default held until the host writes after init
  // Straps pass a synchroniser, so the default is tracked until a host write
  typedef enum logic [1:0] {
    FIELD_STRAP = 2'b01,
    FIELD_HOST = 2'b10
  } field_owner_t;
  field_owner_t owner_q;
  logic [3:0] field_q;
  logic field_wr;

  assign field_wr = wr_hit(i_req, ADDR_FIRST_OUT) && init_done;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      owner_q <= FIELD_STRAP;
    end else begin
      unique case (owner_q)
        FIELD_STRAP: begin
          if (field_wr) begin
            owner_q <= FIELD_HOST;
          end
        end
        FIELD_HOST: begin
          owner_q <= FIELD_HOST;
        end
        default: begin
          owner_q <= FIELD_STRAP;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      field_q <= strap_q;
    end else if (field_wr) begin
      field_q <= i_req.wdata[7:FIELD_LSB];
    end else if (owner_q != FIELD_HOST) begin
      field_q <= strap_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync enables
  logic [1:0] sync_en_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      sync_en_q <= SYNC_EN_RESET[MF_EN_BIT:FR_EN_BIT];
    end else if (wr_hit(i_req, ADDR_SYNC_EN)) begin
      sync_en_q <= i_req.wdata[MF_EN_BIT:FR_EN_BIT];
    end
  end
  assign o_multiframe_sync_enable = sync_en_q[1];
  assign o_frame_sync_enable = sync_en_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered; unmapped addresses read zero
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (i_req.rd) begin
      unique case (i_req.addr)
        ADDR_FIRST_OUT: o_rdata <= {field_q, 4'h0};
        ADDR_SYNC_EN: o_rdata <= {sync_en_q, 6'h00};
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Code decode; divider map is provisional because the source map is unclear
  function automatic out_sel_t decode(input logic [3:0] code);
    out_sel_t s;
    s = '{src: SRC_OFF, divide: 6'h00};
    unique case (code)
      4'h0: begin
        s.src = SRC_OFF;
        s.divide = 6'h00;
      end
      4'h1: begin
        s.src = SRC_2K;
        s.divide = 6'h01;
      end
      4'h2: begin
        s.src = SRC_8K;
        s.divide = 6'h01;
      end
      4'h3: begin
        s.src = SRC_FIRST_ANALOG_PLL;
        s.divide = 6'h02;
      end
      4'h4: begin
        s.src = SRC_DIGITAL;
        s.divide = 6'h01;
      end
      4'h5: begin
        s.src = SRC_FIRST_ANALOG_PLL;
        s.divide = 6'h10;
      end
      4'h6: begin
        s.src = SRC_FIRST_ANALOG_PLL;
        s.divide = 6'h0C;
      end
      4'h7: begin
        s.src = SRC_FIRST_ANALOG_PLL;
        s.divide = 6'h08;
      end
      4'h8: begin
        s.src = SRC_FIRST_ANALOG_PLL;
        s.divide = 6'h06;
      end
      4'h9: begin
        s.src = SRC_FIRST_ANALOG_PLL;
        s.divide = 6'h04;
      end
      4'hA: begin
        s.src = SRC_SECOND_ANALOG_PLL;
        s.divide = 6'h30;
      end
      4'hB: begin
        s.src = SRC_SECOND_ANALOG_PLL;
        s.divide = 6'h10;
      end
      4'hC: begin
        s.src = SRC_SECOND_ANALOG_PLL;
        s.divide = 6'h0C;
      end
      4'hD: begin
        s.src = SRC_SECOND_ANALOG_PLL;
        s.divide = 6'h08;
      end
      4'hE: begin
        s.src = SRC_SECOND_ANALOG_PLL;
        s.divide = 6'h04;
      end
      4'hF: begin
        s.src = SRC_SECOND_ANALOG_PLL;
        s.divide = 6'h02;
      end
    endcase
    return s;
  endfunction

  // Divides apply to the live PLL clocks, so the result follows their setting
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_first_out_sel <= '{src: SRC_OFF, divide: 6'd0};
    end else begin
      o_first_out_sel <= decode(field_q);
    end
  end

endmodule // output_freq_sync_enable_regs

// ===== tb/host_model.sv
// Host model issuing single-cycle register requests on the serial port
`timescale 1ns/1ps
module host_model
  import out_sync_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic [7:0] i_rdata,
  output reg_req_t o_req
);
  initial o_req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk) o_req <= '{1'b1, 1'b0, a, d};
    @(posedge i_ref_clk) o_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk) o_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_ref_clk) o_req <= '0;
    #1 d = i_rdata;
  endtask
endmodule // host_model

// ===== tb/out_sync_monitor.sv
// Port checker for the output frequency and sync enable registers
`timescale 1ns/1ps
module out_sync_monitor
  import out_sync_pkg::*;
#(parameter int INIT_COUNT = INIT_CYCLES) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire reg_req_t i_req,
  input wire logic [7:0] o_rdata,
  input wire logic o_init_done,
  input wire out_sel_t o_first_out_sel,
  input wire logic o_multiframe_sync_enable,
  input wire logic o_frame_sync_enable
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  logic [31:0] cnt_q;
  always_ff @(posedge i_ref_clk) cnt_q <= i_reset ? 32'h0 : cnt_q + 32'h1;
  sequence s_en_wr; i_req.wr && i_req.addr == ADDR_SYNC_EN; endsequence
  sequence s_rd(logic [7:0] a); i_req.rd && i_req.addr == a; endsequence
  //////////////////////////////////////////
  chk_mf_follow: assert property (s_en_wr |=> o_multiframe_sync_enable == $past(i_req.wdata[7]))
    else $error("multiframe enable wrong");
  chk_fr_follow: assert property (s_en_wr |=> o_frame_sync_enable == $past(i_req.wdata[6]))
    else $error("frame enable wrong");
  chk_en_hold: assert property (!i_req.wr |=> $stable({o_multiframe_sync_enable, o_frame_sync_enable}))
    else $error("enables moved");
  chk_en_read: assert property (s_rd(ADDR_SYNC_EN) ##0 !i_req.wr |=>
    o_rdata == {$past(o_multiframe_sync_enable), $past(o_frame_sync_enable), 6'h00}) else $error("enable read");
  chk_low_zero: assert property (s_rd(ADDR_FIRST_OUT) |=> o_rdata[3:0] == 4'h0) else $error("low nibble");
  chk_low_codes: assert property (s_rd(ADDR_FIRST_OUT) |=>
    o_rdata[7:4] > 4'h2 || o_first_out_sel.src == out_src_t'(o_rdata[6:4])) else $error("decode wrong");
  // Window opens on exactly the INIT_COUNT-th edge after reset release
  chk_init_time: assert property ($rose(o_init_done) |-> cnt_q == 32'(INIT_COUNT))
    else $error("init period wrong");
  chk_reset_vals: assert property (disable iff (1'b0) i_reset |=>
    o_multiframe_sync_enable && o_frame_sync_enable && !o_init_done) else $error("reset values");
endmodule // out_sync_monitor
bind output_freq_sync_enable_regs out_sync_monitor #(.INIT_COUNT(INIT_COUNT)) u_mon (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_req(i_req), .o_rdata(o_rdata),
  .o_init_done(o_init_done), .o_first_out_sel(o_first_out_sel),
  .o_multiframe_sync_enable(o_multiframe_sync_enable), .o_frame_sync_enable(o_frame_sync_enable));

// ===== tb/output_freq_sync_enable_regs_tb.sv
// Self-checking bench for the output frequency and sync enable registers
`timescale 1ns/1ps
module output_freq_sync_enable_regs_tb;
  import out_sync_pkg::*;
  logic clk, rst, done, mf, fr;
  logic [3:0] strap;
  logic [7:0] rdata, v;
  reg_req_t req;
  out_sel_t sel;
  int n_fail = 0, checked = 0;
  logic [23:0] rows [8] = '{24'h630000, 24'h638080, 24'h634040, 24'h63FFC0,
    24'h620000, 24'h621F10, 24'h622A20, 24'h62F5F0};
  // Expected {source, divide} for every output code
  logic [8:0] sel_rows [16] = '{9'h000, 9'h041, 9'h081, 9'h0C2, 9'h141, 9'h0D0, 9'h0CC, 9'h0C8,
    9'h0C6, 9'h0C4, 9'h130, 9'h110, 9'h10C, 9'h108, 9'h104, 9'h102};
  output_freq_sync_enable_regs #(.INIT_COUNT(20)) dut (.i_ref_clk(clk), .i_reset(rst),
    .i_first_output_strap_pins(strap[2:0]), .i_sonet_sdh_select_pin(strap[3]), .i_req(req),
    .o_rdata(rdata), .o_init_done(done), .o_first_out_sel(sel),
    .o_multiframe_sync_enable(mf), .o_frame_sync_enable(fr));
  host_model u_host (.i_ref_clk(clk), .i_rdata(rdata), .o_req(req));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic results();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////////////////
  initial begin clk = 0; forever #5 clk = ~clk; end
  initial begin #50000; n_fail++; results(); end
  initial begin
    rst = 1;
    strap = 4'h1;
    repeat (20) @(posedge clk);
    rst <= 0;
    u_host.rd(ADDR_SYNC_EN, v); chk(v, SYNC_EN_RESET);
    u_host.rd(ADDR_FIRST_OUT, v); chk(v, 8'h10);
    chk(8'(sel.src), 8'(SRC_2K));
    u_host.wr(ADDR_FIRST_OUT, 8'h20);
    u_host.rd(ADDR_FIRST_OUT, v); chk(v, 8'h10);
    for (int k = 0; k < 100 && done !== 1'b1; k++) @(posedge clk);
    chk({7'h0, done}, 8'h01);
    foreach (rows[i]) begin
      u_host.wr(rows[i][23:16], rows[i][15:8]);
      u_host.rd(rows[i][23:16], v); chk(v, rows[i][7:0]);
    end
    // Every output code, decoded selection against the expected map
    for (int c = 0; c < 16; c++) begin
      u_host.wr(ADDR_FIRST_OUT, {4'(c), 4'h0});
      u_host.rd(ADDR_FIRST_OUT, v);
      chk(v, {4'(c), 4'h0});
      chk(8'(sel.src), 8'(sel_rows[c][8:6]));
      chk(8'(sel.divide), 8'(sel_rows[c][5:0]));
    end
    // Unmapped place reads as zero
    u_host.rd(8'h64, v); chk(v, 8'h00);
    // Clear both enables so the reset below must restore them
    u_host.wr(ADDR_SYNC_EN, 8'h00);
    u_host.rd(ADDR_SYNC_EN, v);
    chk(v, 8'h00);
    chk({6'h00, mf, fr}, 8'h00);
    @(posedge clk) strap <= 4'h2;
    rst <= 1;
    repeat (6) @(posedge clk);
    rst <= 0;
    u_host.rd(ADDR_FIRST_OUT, v); chk(v, 8'h20);
    chk(8'(sel.src), 8'(SRC_8K));
    chk({7'h00, done}, 8'h00);
    u_host.rd(ADDR_SYNC_EN, v); chk(v, SYNC_EN_RESET);
    chk({6'h00, mf, fr}, 8'h03);
    // Window closed again after reset, so this write must be dropped
    u_host.wr(ADDR_FIRST_OUT, 8'h50);
    u_host.rd(ADDR_FIRST_OUT, v);
    chk(v, 8'h20);
    results();
  end
endmodule // output_freq_sync_enable_regs_tb
